// ==== hw/owp_pkg.sv ====
// Purpose: constants and types for the one-time-programmable word programmer
// Assumes: 10 MHz clk_sys; supplies switched by external regulators on enable pins
// Notes:   times are kept in ns and converted to cycles here
package owp_pkg;

  localparam int          ADDR_W          = 17;
  localparam int          DATA_W          = 16;
  localparam int          CLK_PERIOD_NS   = 100;
  // nominal 50 us sits mid-window of 47.5..52.5 us
  localparam int          PULSE_NS        = 50000;
  localparam int          PULSE_MIN_NS    = 47500;
  localparam int          PULSE_MAX_NS    = 52500;
  localparam int          PULSE_CYC       = PULSE_NS / CLK_PERIOD_NS;
  // setup/hold times of 2 us, and supply settling between switch steps
  localparam int          SETUP_NS        = 2000;
  localparam int          SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          OE_ACCESS_NS    = 150;
  localparam int          OE_ACCESS_CYC   = (OE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  MAX_RETRY       = 4'ha;
  localparam logic [15:0] TIMER_W1        = 16'h0001;

  typedef enum logic [1:0] {
    OWP_OP_PROGRAM,
    OWP_OP_READ_ID,
    OWP_OP_NONE
  } owp_op_t;

  // supply selection lines to the external regulators
  typedef struct packed {
    logic vcc_prog;   // logic supply at programming level (6.5 V) else 5.0 V
    logic vpp_on;     // programming supply at 13.0 V else 5.0 V
    logic vcc_on;     // logic supply present
  } owp_supply_t;

  typedef struct packed {
    logic              busy;
    logic              done;
    logic              pass;
    logic              fail;
  } owp_status_t;

endpackage : owp_pkg

// ==== hw/owp_programmer.sv ====
// Purpose: drives an OTP word memory through its pins with the rapid algorithm
// Assumes: image words come from a same-clock source addressed by img_addr
// Notes:   one-cycle image latency; all outputs registered; ce freezes state
`timescale 1ns/1ns
module owp_programmer #(
  parameter int unsigned WORDS     = 131072,
  parameter int unsigned PULSE_CYC = owp_pkg::PULSE_CYC,
  parameter int unsigned SETUP_CYC = owp_pkg::SETUP_CYC
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  input  wire logic                         start,
  input  wire owp_pkg::owp_op_t             op,
  input  wire logic [owp_pkg::DATA_W-1:0]   img_data,
  output logic      [owp_pkg::ADDR_W-1:0]   img_addr,
  output logic      [owp_pkg::ADDR_W-1:0]   mem_addr,
  output logic                              chip_sel_n,
  output logic                              out_en_n,
  output logic                              program_strobe_n,
  output logic                              id_select_address_line,
  input  wire logic [owp_pkg::DATA_W-1:0]   mem_data_in,
  output logic      [owp_pkg::DATA_W-1:0]   mem_data_out,
  output logic                              mem_data_oe_n,
  output owp_pkg::owp_supply_t              supply,
  output owp_pkg::owp_status_t              status,
  output logic      [owp_pkg::DATA_W-1:0]   id_maker,
  output logic      [owp_pkg::DATA_W-1:0]   id_type,
  output logic      [owp_pkg::ADDR_W-1:0]   fail_addr
);

  typedef enum logic [4:0] {
    S_IDLE, S_VCC_UP, S_VPP_UP, S_P1_SETUP, S_P1_PULSE, S_P1_HOLD,
    S_V_SETUP, S_V_READ, S_V_CHECK, S_R_SETUP, S_R_PULSE, S_R_HOLD,
    S_VPP_DN, S_VCC_DN, S_F_SETUP, S_F_READ, S_F_CHECK,
    S_ID_SETUP, S_ID_READ, S_ID_NEXT, S_ID_END, S_END
  } owp_state_t;

  owp_state_t                    state_r;
  logic [15:0]                   timer_r;
  logic [owp_pkg::ADDR_W-1:0]    addr_r;
  logic [3:0]                    retry_r;
  logic                          bad_r;
  logic                          final_fail_r;
  logic [owp_pkg::DATA_W-1:0]    din_s1_r;
  logic [owp_pkg::DATA_W-1:0]    din_s2_r;

  localparam logic [owp_pkg::ADDR_W-1:0] LAST_ADDR = owp_pkg::ADDR_W'(WORDS - 1);

  function automatic logic [15:0] cyc(input int unsigned n);
    cyc = 16'(n);
  endfunction : cyc

  wire logic timer_done = (timer_r == 16'h0000);
  wire logic last_addr  = (addr_r == LAST_ADDR);

  // ------------------------------------------------------------
  // pin input synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      din_s1_r <= 16'h0000;
      din_s2_r <= 16'h0000;
    end else if (ce) begin
      din_s1_r <= mem_data_in;
      din_s2_r <= din_s1_r;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r      <= S_IDLE;
      timer_r      <= 16'h0000;
      addr_r       <= '0;
      retry_r      <= 4'h0;
      bad_r        <= 1'b0;
      final_fail_r <= 1'b0;
    end else if (ce) begin
      if (!timer_done) begin
        timer_r <= timer_r - owp_pkg::TIMER_W1;
      end
      case (state_r)
        S_IDLE: begin
          if (start && op == owp_pkg::OWP_OP_PROGRAM) begin
            addr_r       <= '0;
            bad_r        <= 1'b0;
            final_fail_r <= 1'b0;
            timer_r      <= cyc(SETUP_CYC);
            state_r      <= S_VCC_UP;
          end else if (start && op == owp_pkg::OWP_OP_READ_ID) begin
            addr_r  <= '0;
            timer_r <= cyc(SETUP_CYC);
            state_r <= S_ID_SETUP;
          end
        end
        // both supplies rise on the same edge, so neither leads the other
        S_VCC_UP: if (timer_done) begin
          timer_r <= cyc(SETUP_CYC);
          state_r <= S_VPP_UP;
        end
        S_VPP_UP: if (timer_done) begin
          timer_r <= cyc(SETUP_CYC);
          state_r <= S_P1_SETUP;
        end
        // load one short: a timed state lasts one cycle past the zero count
        S_P1_SETUP: if (timer_done) begin
          timer_r <= cyc(PULSE_CYC - 1);
          state_r <= S_P1_PULSE;
        end
        S_P1_PULSE: if (timer_done) begin
          timer_r <= cyc(SETUP_CYC);
          state_r <= S_P1_HOLD;
        end
        // single pulse per word, no read-back in this pass
        S_P1_HOLD: if (timer_done) begin
          timer_r <= cyc(SETUP_CYC);
          if (last_addr) begin
            addr_r  <= '0;
            retry_r <= 4'h0;
            state_r <= S_V_SETUP;
          end else begin
            addr_r  <= addr_r + 1'b1;
            state_r <= S_P1_SETUP;
          end
        end
        S_V_SETUP: if (timer_done) begin
          timer_r <= cyc(owp_pkg::OE_ACCESS_CYC + 2);
          state_r <= S_V_READ;
        end
        S_V_READ: if (timer_done) begin
          state_r <= S_V_CHECK;
        end
        S_V_CHECK: begin
          timer_r <= cyc(SETUP_CYC);
          if (din_s2_r == img_data) begin
            retry_r <= 4'h0;
            if (last_addr) begin
              state_r <= S_VPP_DN;
            end else begin
              addr_r  <= addr_r + 1'b1;
              state_r <= S_V_SETUP;
            end
          end else if (retry_r == owp_pkg::MAX_RETRY) begin
            bad_r   <= 1'b1;
            state_r <= S_VPP_DN;
          end else begin
            retry_r <= retry_r + 4'h1;
            state_r <= S_R_SETUP;
          end
        end
        // data and strobe settle before every retry pulse, as in the first pass
        S_R_SETUP: if (timer_done) begin
          timer_r <= cyc(PULSE_CYC - 1);
          state_r <= S_R_PULSE;
        end
        S_R_PULSE: if (timer_done) begin
          timer_r <= cyc(SETUP_CYC);
          state_r <= S_R_HOLD;
        end
        S_R_HOLD: if (timer_done) begin
          timer_r <= cyc(SETUP_CYC);
          state_r <= S_V_SETUP;
        end
        // programming supply off before the logic supply drops
        S_VPP_DN: if (timer_done) begin
          timer_r <= cyc(SETUP_CYC);
          state_r <= S_VCC_DN;
        end
        S_VCC_DN: if (timer_done) begin
          timer_r <= cyc(SETUP_CYC);
          addr_r  <= '0;
          state_r <= bad_r ? S_END : S_F_SETUP;
        end
        S_F_SETUP: if (timer_done) begin
          timer_r <= cyc(owp_pkg::OE_ACCESS_CYC + 2);
          state_r <= S_F_READ;
        end
        S_F_READ: if (timer_done) begin
          state_r <= S_F_CHECK;
        end
        S_F_CHECK: begin
          timer_r <= cyc(SETUP_CYC);
          if (din_s2_r != img_data) begin
            final_fail_r <= 1'b1;
          end
          if (last_addr) begin
            state_r <= S_END;
          end else begin
            addr_r  <= addr_r + 1'b1;
            state_r <= S_F_SETUP;
          end
        end
        S_ID_SETUP: if (timer_done) begin
          timer_r <= cyc(owp_pkg::OE_ACCESS_CYC + 2);
          state_r <= S_ID_READ;
        end
        S_ID_READ: if (timer_done) begin
          state_r <= S_ID_NEXT;
        end
        S_ID_NEXT: begin
          timer_r <= cyc(SETUP_CYC);
          if (addr_r[0]) begin
            state_r <= S_ID_END;
          end else begin
            addr_r  <= addr_r + 1'b1;
            state_r <= S_ID_SETUP;
          end
        end
        S_ID_END: if (timer_done) begin
          state_r <= S_END;
        end
        S_END: state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // pins and results
  // ------------------------------------------------------------
  wire logic pulsing  = (state_r == S_P1_PULSE) || (state_r == S_R_PULSE);
  wire logic prog_win = (state_r == S_P1_SETUP) || (state_r == S_P1_HOLD) || pulsing ||
                        (state_r == S_R_SETUP) || (state_r == S_R_HOLD);
  wire logic reading  = (state_r == S_V_READ) || (state_r == S_F_READ) || (state_r == S_ID_READ);
  wire logic hi_vcc   = (state_r >= S_VCC_UP) && (state_r <= S_VPP_DN);
  wire logic hi_vpp   = (state_r >= S_VCC_UP) && (state_r <= S_R_HOLD);
  wire logic id_mode  = (state_r >= S_ID_SETUP) && (state_r <= S_ID_END);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      img_addr               <= '0;
      mem_addr               <= '0;
      chip_sel_n             <= 1'b1;
      out_en_n               <= 1'b1;
      program_strobe_n       <= 1'b1;
      id_select_address_line <= 1'b0;
      mem_data_out           <= 16'h0000;
      mem_data_oe_n          <= 1'b1;
      supply                 <= '0;
    end else if (ce) begin
      img_addr               <= addr_r;
      mem_addr               <= addr_r;
      chip_sel_n             <= !(pulsing || reading);
      out_en_n               <= !reading;
      program_strobe_n       <= !prog_win;
      id_select_address_line <= id_mode;
      mem_data_out           <= img_data;
      mem_data_oe_n          <= !prog_win;
      supply.vcc_on          <= (state_r != S_IDLE);
      supply.vcc_prog        <= hi_vcc;
      supply.vpp_on          <= hi_vpp;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status    <= '0;
      id_maker  <= 16'h0000;
      id_type   <= 16'h0000;
      fail_addr <= '0;
    end else if (ce) begin
      status.busy <= (state_r != S_IDLE);
      if (state_r == S_IDLE && start && op != owp_pkg::OWP_OP_NONE) begin
        status.done <= 1'b0;
        status.pass <= 1'b0;
        status.fail <= 1'b0;
      end
      if (state_r == S_V_CHECK && din_s2_r != img_data && retry_r == owp_pkg::MAX_RETRY) begin
        fail_addr <= addr_r;
      end
      if (state_r == S_ID_NEXT) begin
        // upper byte of the id word reads as zero
        if (addr_r[0]) id_type  <= {8'h00, din_s2_r[7:0]};
        else           id_maker <= {8'h00, din_s2_r[7:0]};
      end
      if (state_r == S_END) begin
        status.done <= 1'b1;
        status.pass <= !bad_r && !final_fail_r && !id_select_address_line;
        status.fail <= bad_r || final_fail_r;
      end
    end
  end

endmodule : owp_programmer

// ==== test/owp_sva.sv ====
// Purpose: pin order and pulse checks on the otp programmer
// Assumes: sees top-level ports only
// Notes:   pulse count restarts whenever the address moves
`timescale 1ns/1ns
module owp_sva #(
  parameter int unsigned PULSE_CYC = 5
) (
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire logic [16:0]          mem_addr,
  input wire logic                 chip_sel_n,
  input wire logic                 program_strobe_n,
  input wire logic                 id_select_address_line,
  input wire owp_pkg::owp_supply_t supply,
  input wire owp_pkg::owp_status_t status
);
  logic [15:0] lo_r;
  logic [3:0]  np_r;
  logic [16:0] pa_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // --------------------------------------------------
  // helper counters
  // --------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n || chip_sel_n || program_strobe_n) lo_r <= 16'h0000;
    else lo_r <= lo_r + 16'h0001;
  end
  always_ff @(posedge clk_sys) begin
    pa_r <= mem_addr;
    if (!rst_n || mem_addr != pa_r) np_r <= 4'h0;
    else if (lo_r == 16'h0001) np_r <= np_r + 4'h1;
  end
  // --------------------------------------------------
  // assertions
  // --------------------------------------------------
  pulse_width_a: assert property ($rose(chip_sel_n) && !program_strobe_n |-> lo_r == PULSE_CYC)
    else $error("program pulse width off");
  supply_levels_a: assert property (supply.vpp_on |-> supply.vcc_on && supply.vcc_prog)
    else $error("vpp up without logic supply");
  vcc_with_vpp_a: assert property ($rose(supply.vpp_on) |-> $rose(supply.vcc_prog) && $rose(supply.vcc_on))
    else $error("programming supply led the logic supply");
  vcc_off_last_a: assert property ($fell(supply.vcc_on) |-> !supply.vpp_on && !supply.vcc_prog)
    else $error("logic supply dropped before programming supply");
  strobe_supply_a: assert property (!chip_sel_n && !program_strobe_n |-> supply.vpp_on)
    else $error("pulse without programming supply");
  first_addr_a: assert property ($rose(supply.vpp_on) |-> mem_addr == 17'h00000)
    else $error("sequence not at first address");
  retry_cap_a: assert property (np_r <= 4'ha)
    else $error("too many pulses on one word");
  fail_verdict_a: assert property (status.fail |-> !status.pass)
    else $error("failed part reported good");
  pass_lowered_a: assert property (status.done && status.pass |-> !supply.vpp_on && !supply.vcc_prog)
    else $error("supplies still high at pass");
  id_mode_a: assert property (id_select_address_line |-> program_strobe_n && !supply.vpp_on)
    else $error("id mode during programming");
  pulse_c: cover property ($rose(chip_sel_n) && !program_strobe_n);
  fail_c: cover property ($rose(status.fail));
  id_c: cover property ($rose(id_select_address_line));
endmodule : owp_sva

bind owp_programmer owp_sva #(.PULSE_CYC(PULSE_CYC)) u_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
  .program_strobe_n(program_strobe_n), .id_select_address_line(id_select_address_line),
  .supply(supply), .status(status));

// ==== test/owp_mem_model.sv ====
// Purpose: behavioural otp word memory for the programmer bench
// Assumes: erased words read all ones; pulses clear bits
// Notes:   one weak word may need several pulses to take
`timescale 1ns/1ns
module owp_mem_model #(
  parameter int unsigned WORDS = 4,
  parameter logic [7:0]  MAKER = 8'h5a, // arbitrary value
  parameter logic [7:0]  KIND  = 8'h3c  // arbitrary value
) (
  input  wire logic                 clk_sys,
  input  wire logic                 wipe,
  input  wire logic [16:0]          mem_addr,
  input  wire logic                 chip_sel_n,
  input  wire logic                 out_en_n,
  input  wire logic                 program_strobe_n,
  input  wire logic                 id_select_address_line,
  input  wire logic [15:0]          mem_data_out,
  input  wire logic                 mem_data_oe_n,
  input  wire owp_pkg::owp_supply_t supply,
  input  wire logic [16:0]          weak_addr,
  input  wire logic [3:0]           weak_need,
  output logic [15:0]               mem_data_in
);
  logic [15:0] mem [WORDS];
  int          cnt [WORDS];
  int          pulse_total;
  logic        cs_q;
  logic [15:0] val;
  logic [15:0] last;
  int          a;
  assign a = mem_addr % WORDS;
  always_comb begin
    if (id_select_address_line) val = mem_addr[0] ? {8'h00, KIND} : {8'h00, MAKER};
    else val = mem[a];
  end
  // released bus shows the inverse so stale data cannot match
  // reads need the logic supply and a released data bus from the programmer
  assign mem_data_in = (!chip_sel_n && !out_en_n && program_strobe_n && mem_data_oe_n && supply.vcc_on) ? val : ~last;
  always @(posedge clk_sys) begin
    cs_q <= chip_sel_n;
    if (!chip_sel_n && !out_en_n) last <= val;
    if (wipe) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] = 16'hffff;
        cnt[i] = 0;
      end
      pulse_total = 0;
    end else if (chip_sel_n && !cs_q && !program_strobe_n && !mem_data_oe_n && supply.vpp_on && supply.vcc_prog) begin
      cnt[a]++;
      pulse_total++;
      if (cnt[a] >= ((a == weak_addr) ? weak_need : 1)) mem[a] = mem[a] & mem_data_out;
    end
  end
endmodule : owp_mem_model

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the otp word programmer
// Assumes: shortened counts WORDS 4, PULSE_CYC 5, SETUP_CYC 2
// Notes:   inputs change on the falling edge
`timescale 1ns/1ns
module testbench;
  localparam int unsigned WORDS = 4;
  logic                 clk_sys = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 start = 1'b0;
  logic                 ce = 1'b1;
  logic                 wipe = 1'b0;
  owp_pkg::owp_op_t     op = owp_pkg::OWP_OP_NONE;
  logic [16:0]          weak_addr = 17'h00000;
  logic [3:0]           weak_need = 4'h1;
  logic [16:0]          img_addr, mem_addr, fail_addr;
  logic [15:0]          img_data, mem_data_in, mem_data_out, id_maker, id_type;
  logic                 chip_sel_n, out_en_n, program_strobe_n, id_sel, mem_data_oe_n;
  owp_pkg::owp_supply_t supply;
  owp_pkg::owp_status_t status;
  int                   err_count = 0;
  int                   checked = 0;
  always #50 clk_sys = ~clk_sys;
  assign img_data = 16'h1234 + img_addr[15:0] * 16'h0101;
  owp_programmer #(.WORDS(WORDS), .PULSE_CYC(5), .SETUP_CYC(2)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .start(start), .op(op), .img_data(img_data),
    .img_addr(img_addr), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .program_strobe_n(program_strobe_n), .id_select_address_line(id_sel), .mem_data_in(mem_data_in),
    .mem_data_out(mem_data_out), .mem_data_oe_n(mem_data_oe_n), .supply(supply), .status(status),
    .id_maker(id_maker), .id_type(id_type), .fail_addr(fail_addr));
  owp_mem_model #(.WORDS(WORDS)) u_mem (
    .clk_sys(clk_sys), .wipe(wipe), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .program_strobe_n(program_strobe_n), .id_select_address_line(id_sel), .mem_data_out(mem_data_out),
    .mem_data_oe_n(mem_data_oe_n), .supply(supply), .weak_addr(weak_addr), .weak_need(weak_need),
    .mem_data_in(mem_data_in));
  // --------------------------------------------------
  // shared tasks
  // --------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic run(input owp_pkg::owp_op_t o, input logic [16:0] wa, input logic [3:0] wn);
    int n;
    @(negedge clk_sys);
    wipe = 1'b1;
    weak_addr = wa;
    weak_need = wn;
    @(negedge clk_sys);
    wipe = 1'b0;
    op = o;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    n = 0;
    while (status.busy !== 1'b1 && n < 10) begin @(negedge clk_sys); n++; end
    if (n >= 10) err_count++;
    n = 0;
    while (status.busy !== 1'b0 && n < 5000) begin @(negedge clk_sys); n++; end
    if (n >= 5000) err_count++;
  endtask : run
  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  task automatic t_idle();
    check({program_strobe_n, chip_sel_n, supply, status}, {2'b11, 3'h0, 4'h0});
    op = owp_pkg::OWP_OP_NONE;
    start = 1'b1;
    repeat (6) @(negedge clk_sys);
    start = 1'b0;
    check(status.busy, 1'b0);
    // a held-low clock enable must keep a valid start from being taken
    ce = 1'b0;
    op = owp_pkg::OWP_OP_PROGRAM;
    start = 1'b1;
    repeat (3) @(negedge clk_sys);
    check({supply, status}, 7'h00);
    start = 1'b0;
    ce = 1'b1;
    @(negedge clk_sys);
    check(status.busy, 1'b0);
  endtask : t_idle
  task automatic t_id();
    run(owp_pkg::OWP_OP_READ_ID, 17'h00000, 4'h1);
    check(status.done, 1'b1);
    check(id_maker, 16'h005a);
    check(id_type, 16'h003c);
  endtask : t_id
  task automatic t_prog();
    run(owp_pkg::OWP_OP_PROGRAM, 17'h00002, 4'h3);
    check({status.done, status.pass, status.fail}, 3'b110);
    check(u_mem.pulse_total, WORDS + 2);
    for (int i = 0; i < WORDS; i++) check(u_mem.mem[i], 16'h1234 + i * 16'h0101);
    check(supply, 3'h0);
  endtask : t_prog
  task automatic t_fail();
    run(owp_pkg::OWP_OP_PROGRAM, 17'h00001, 4'hc);
    check({status.pass, status.fail}, 2'b01);
    check(fail_addr, 17'h00001);
    check(u_mem.cnt[1], 11);
  endtask : t_fail
  initial begin
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    t_idle();
    t_id();
    t_prog();
    t_fail();
    finish_test();
  end
  // generous against a few hundred cycles of expected work
  initial begin
    repeat (30000) @(posedge clk_sys);
    err_count++;
    finish_test();
  end
endmodule : testbench
